// [common/mac_fc_pkg.sv]
// Purpose: constants for the flow-control, vlan tag and wake filter slice
// Assumes: apb with 32-bit data, register index times four is the byte address
// Notes:
// What this block does
// - with enable set, decode rx pause frames and hold tx for time x slot.
// - with enable clear, no control frame decode and no tx pause.
// - pause only in full duplex; half duplex uses backpressure instead.
// - busy reads one while pause frame or backpressure is transmitted.
// - busy clears by itself when pause frame transmission ends.
// - primary tag compared with rx bytes 13 and 14 flags vlan frame.
// - secondary tag compared with rx bytes 13 and 14 flags vlan frame.
// - vlan frames raise max legal length from 1518 to 1522 bytes.
// - after reset the wake filter pointer selects word zero.
// - each wake filter write loads next word then advances pointer.
// - after eight words the pointer wraps to the first entry.
// - wake filter port is write-only, resets to zero, reads zero.
// - pause time field of register goes into transmitted pause frames.
// - no pause frames or backpressure while transmitter disabled.
package mac_fc_pkg;
	localparam logic [3:0]  IDX_FLOW         = 4'h8;
	localparam logic [3:0]  IDX_TAG_PRI      = 4'h9;
	localparam logic [3:0]  IDX_TAG_SEC      = 4'ha;
	localparam logic [3:0]  IDX_WAKE         = 4'hb;
	localparam logic [3:0]  IDX_SOFT_RST     = 4'hd;
	localparam logic [31:0] FLOW_RESET       = 32'h00000000;
	localparam logic [31:0] VLAN_RESET       = 32'h00000000;
	localparam logic [31:0] WAKE_RESET       = 32'h00000000;
	localparam int          FLOW_BUSY_BIT    = 0;
	localparam int          FLOW_EN_BIT      = 1;
	localparam int          FLOW_PASS_BIT    = 2;
	localparam int          FLOW_TIME_LSB    = 16;
	localparam int          WAKE_WORDS       = 8;
	localparam int          PTR_W            = 3;
	localparam logic [10:0] LEN_PLAIN        = 11'h5ee;
	localparam logic [10:0] LEN_VLAN         = 11'h5f2;
	localparam logic [4:0]  TAG_BYTE_HI      = 5'h0c;
	localparam logic [4:0]  TAG_BYTE_LO      = 5'h0d;
	localparam logic [4:0]  OP_BYTE_HI       = 5'h10;
	localparam logic [4:0]  OP_BYTE_LO       = 5'h11;
	localparam logic [4:0]  QT_BYTE_HI       = 5'h12;
	localparam logic [4:0]  QT_BYTE_LO       = 5'h13;
	localparam logic [15:0] MAC_CTRL_TYPE    = 16'h8808;
	localparam logic [15:0] PAUSE_OPCODE     = 16'h0001;
	localparam int          CLK_MHZ          = 125;
	localparam int          SLOT_BITS        = 512;
	localparam int          SLOT_NS_100      = SLOT_BITS * 10;
	localparam int          SLOT_NS_10       = SLOT_BITS * 100;
	localparam logic [12:0] SLOT_CYC_100     = 13'((SLOT_NS_100 * CLK_MHZ) / 1000);
	localparam logic [12:0] SLOT_CYC_10      = 13'((SLOT_NS_10 * CLK_MHZ) / 1000);
	localparam logic [31:0] SOFT_RST_KEY     = 32'h00000001;
endpackage : mac_fc_pkg

// [core/slot_timer.sv]
// Purpose: pause hold-off timer, counts quanta of one slot time each
// Assumes: speed input stable while counting
// Notes: a new load restarts the count, as a fresh pause frame overrides the old one
module slot_timer
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic [15:0] quanta,
	input  wire logic        speed_100,
	output logic             active
);
	logic [15:0] quanta_q;
	logic [12:0] cyc_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			quanta_q <= 16'h0000;
			cyc_q    <= 13'h0000;
		end
		else if (load)
		begin
			quanta_q <= quanta;
			cyc_q    <= 13'h0000;
		end
		else if (quanta_q != 16'h0000)
		begin
			// one quantum is 512 bit times at the current link speed
			if (cyc_q == (speed_100 ? mac_fc_pkg::SLOT_CYC_100 : mac_fc_pkg::SLOT_CYC_10) - 13'h0001)
			begin
				cyc_q    <= 13'h0000;
				quanta_q <= quanta_q - 16'h0001;
			end
			else
			begin
				cyc_q <= cyc_q + 13'h0001;
			end
		end
	end

	assign active = (quanta_q != 16'h0000);
endmodule : slot_timer

// [core/mac_flow_vlan_wakeup_cfg.sv]
// Purpose: mac flow control, vlan tag detect and wake filter loading port
// Assumes: rx bytes arrive one per cycle with a start pulse; tx side reports frame done
// Notes: apb slave with zero wait states; unmapped addresses read zero, no error
//
// The APB register port was left to the implementer.
module mac_flow_vlan_wakeup_cfg
(
	input  wire logic        CLK_SYS,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        FULL_DUPLEX,
	input  wire logic        SPEED_100,
	input  wire logic        TX_ENABLE,
	input  wire logic        RX_SOF,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_EOF,
	input  wire logic        RX_GOOD,
	input  wire logic        RX_CONGESTED,
	input  wire logic        PAUSE_TX_DONE,
	output logic             TX_HOLD,
	output logic             PAUSE_TX_REQ,
	output logic [15:0]      PAUSE_TX_TIME,
	output logic             BACKPRESSURE,
	output logic             RX_VLAN,
	output logic [10:0]      RX_MAX_LEN,
	output logic             RX_PAUSE_SEEN,
	output logic             WAKE_WR,
	output logic [2:0]       WAKE_IDX,
	output logic [31:0]      WAKE_DATA
);
	logic [31:0]  flow_q;
	logic [15:0]  tag_primary_q;
	logic [15:0]  tag_secondary_q;
	logic [2:0]   wake_ptr_q;
	logic         busy_q;
	logic         pause_req_q;
	logic         bp_q;
	logic [4:0]   rx_pos_q;
	logic [15:0]  rx_tag_q;
	logic [15:0]  rx_type_q;
	logic [15:0]  rx_op_q;
	logic [15:0]  rx_quanta_q;
	logic         vlan_q;
	logic [10:0]  max_len_q;
	logic         hold_q;
	logic         pause_seen_q;
	logic         timer_load;
	logic         timer_active;
	logic         wake_wr_q;
	logic [2:0]   wake_idx_q;
	logic [31:0]  wake_data_q;
	logic [31:0]  prdata_q;
	logic         soft_rst;
	logic         wr_en;
	logic         rd_en;
	logic         pause_en;
	logic         half_bp_en;

	function automatic logic hit(input logic [11:0] addr, input logic [3:0] idx);
		hit = (addr[11:2] == {6'h00, idx}) && (addr[1:0] == 2'b00);
	endfunction : hit

	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	assign soft_rst = wr_en && hit(PADDR, mac_fc_pkg::IDX_SOFT_RST)
		&& (PWDATA == mac_fc_pkg::SOFT_RST_KEY);
	assign pause_en   = flow_q[mac_fc_pkg::FLOW_EN_BIT] && FULL_DUPLEX;
	assign half_bp_en = flow_q[mac_fc_pkg::FLOW_EN_BIT] && !FULL_DUPLEX;

	// flow control register; busy bit position is never stored from a write
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			flow_q <= mac_fc_pkg::FLOW_RESET;
		end
		else if (wr_en && hit(PADDR, mac_fc_pkg::IDX_FLOW))
		begin
			flow_q <= {PWDATA[31:16], 13'h0000, PWDATA[2:1], 1'b0};
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tag_primary_q   <= mac_fc_pkg::VLAN_RESET[15:0];
			tag_secondary_q <= mac_fc_pkg::VLAN_RESET[15:0];
		end
		else if (wr_en)
		begin
			if (hit(PADDR, mac_fc_pkg::IDX_TAG_PRI))
			begin
				tag_primary_q <= PWDATA[15:0];
			end
			if (hit(PADDR, mac_fc_pkg::IDX_TAG_SEC))
			begin
				tag_secondary_q <= PWDATA[15:0];
			end
		end
	end

	// wake filter port: pointer walks the eight words and wraps
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wake_ptr_q  <= 3'h0;
			wake_wr_q   <= 1'b0;
			wake_idx_q  <= 3'h0;
			wake_data_q <= mac_fc_pkg::WAKE_RESET;
		end
		else if (soft_rst)
		begin
			wake_ptr_q <= 3'h0;
			wake_wr_q  <= 1'b0;
		end
		else if (wr_en && hit(PADDR, mac_fc_pkg::IDX_WAKE))
		begin
			wake_wr_q   <= 1'b1;
			wake_idx_q  <= wake_ptr_q;
			wake_data_q <= PWDATA;
			// a 3-bit pointer wraps after word seven by itself
			wake_ptr_q  <= wake_ptr_q + 3'h1;
		end
		else
		begin
			wake_wr_q <= 1'b0;
		end
	end

	// read mux; data registered in setup so the access phase needs no wait
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			prdata_q <= 32'h00000000;
		end
		else if (rd_en)
		begin
			if (hit(PADDR, mac_fc_pkg::IDX_FLOW))
			begin
				prdata_q <= {flow_q[31:1], busy_q};
			end
			else if (hit(PADDR, mac_fc_pkg::IDX_TAG_PRI))
			begin
				prdata_q <= {16'h0000, tag_primary_q};
			end
			else if (hit(PADDR, mac_fc_pkg::IDX_TAG_SEC))
			begin
				prdata_q <= {16'h0000, tag_secondary_q};
			end
			else
			begin
				// wake port and unmapped addresses read zero
				prdata_q <= 32'h00000000;
			end
		end
	end

	// rx parser: offsets count from byte 0 of destination address
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rx_pos_q    <= 5'h00;
			rx_tag_q    <= 16'h0000;
			rx_op_q     <= 16'h0000;
			rx_quanta_q <= 16'h0000;
		end
		else if (RX_SOF)
		begin
			rx_pos_q <= 5'h00;
		end
		else if (RX_VALID)
		begin
			if (rx_pos_q != 5'h1f)
			begin
				rx_pos_q <= rx_pos_q + 5'h01;
			end
			if (rx_pos_q == mac_fc_pkg::TAG_BYTE_HI)
			begin
				rx_tag_q[15:8] <= RX_DATA;
			end
			if (rx_pos_q == mac_fc_pkg::TAG_BYTE_LO)
			begin
				rx_tag_q[7:0] <= RX_DATA;
			end
			if (rx_pos_q == mac_fc_pkg::OP_BYTE_HI)
			begin
				rx_op_q[15:8] <= RX_DATA;
			end
			if (rx_pos_q == mac_fc_pkg::OP_BYTE_LO)
			begin
				rx_op_q[7:0] <= RX_DATA;
			end
			if (rx_pos_q == mac_fc_pkg::QT_BYTE_HI)
			begin
				rx_quanta_q[15:8] <= RX_DATA;
			end
			if (rx_pos_q == mac_fc_pkg::QT_BYTE_LO)
			begin
				rx_quanta_q[7:0] <= RX_DATA;
			end
		end
	end

	assign rx_type_q = rx_tag_q;

	// vlan detect; a tag of zero is compared like any other, so it matches rx bytes of zero
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			vlan_q    <= 1'b0;
			max_len_q <= mac_fc_pkg::LEN_PLAIN;
		end
		else if (RX_SOF)
		begin
			vlan_q    <= 1'b0;
			max_len_q <= mac_fc_pkg::LEN_PLAIN;
		end
		else if (RX_VALID && rx_pos_q == mac_fc_pkg::TAG_BYTE_LO)
		begin
			if ((tag_primary_q == {rx_tag_q[15:8], RX_DATA})
				|| (tag_secondary_q == {rx_tag_q[15:8], RX_DATA}))
			begin
				vlan_q    <= 1'b1;
				max_len_q <= mac_fc_pkg::LEN_VLAN;
			end
		end
	end

	// pause decode at end of a good frame
	assign timer_load = RX_EOF && RX_GOOD && pause_en
		&& rx_type_q == mac_fc_pkg::MAC_CTRL_TYPE
		&& rx_op_q == mac_fc_pkg::PAUSE_OPCODE;

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			pause_seen_q <= 1'b0;
			hold_q       <= 1'b0;
		end
		else
		begin
			pause_seen_q <= timer_load;
			hold_q       <= timer_active && pause_en;
		end
	end

	slot_timer u_slot_timer
	(
		.clk       (CLK_SYS),
		.rst_n     (RESETN),
		.load      (timer_load),
		.quanta    (rx_quanta_q),
		.speed_100 (SPEED_100),
		.active    (timer_active)
	);

	// tx of pause frames and backpressure, busy tracking
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			pause_req_q <= 1'b0;
			bp_q        <= 1'b0;
			busy_q      <= 1'b0;
		end
		else
		begin
			bp_q <= half_bp_en && RX_CONGESTED && TX_ENABLE;
			if (!TX_ENABLE)
			begin
				pause_req_q <= 1'b0;
			end
			else if (pause_req_q && PAUSE_TX_DONE)
			begin
				pause_req_q <= 1'b0;
			end
			else if (pause_en && RX_CONGESTED && !busy_q)
			begin
				pause_req_q <= 1'b1;
			end
			// busy follows whichever transmission is in progress
			busy_q <= (pause_req_q && !(PAUSE_TX_DONE || !TX_ENABLE))
				|| (pause_en && RX_CONGESTED && TX_ENABLE && !busy_q)
				|| (half_bp_en && RX_CONGESTED && TX_ENABLE);
		end
	end

	assign PRDATA        = prdata_q;
	assign PREADY        = 1'b1;
	assign PSLVERR       = 1'b0;
	assign TX_HOLD       = hold_q;
	assign PAUSE_TX_REQ  = pause_req_q;
	assign PAUSE_TX_TIME = flow_q[31:mac_fc_pkg::FLOW_TIME_LSB];
	assign BACKPRESSURE  = bp_q;
	assign RX_VLAN       = vlan_q;
	assign RX_MAX_LEN    = max_len_q;
	assign RX_PAUSE_SEEN = pause_seen_q;
	assign WAKE_WR       = wake_wr_q;
	assign WAKE_IDX      = wake_idx_q;
	assign WAKE_DATA     = wake_data_q;
endmodule : mac_flow_vlan_wakeup_cfg

// [test/link_partner.sv]
// Purpose: far side model, feeds rx bytes and ends pause sends
// Assumes: one byte a cycle, start pulse one cycle before byte 0
// Notes: idle data toggles so a stale byte never looks live
module link_partner
(
	input  wire logic       clk,
	input  wire logic [3:0] lag,
	input  wire logic       req,
	output logic            sof,
	output logic            vld,
	output logic [7:0]      data,
	output logic            eof,
	output logic            good,
	output logic            done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	initial {sof, vld, eof, good, done, cnt, data} = '0;
	always @(posedge clk)
	begin
		if (!vld && !sof)
			data <= ~data;
		done <= req && !done && cnt == lag;
		cnt <= (req && !done) ? cnt + 4'h1 : 4'h0;
	end
	task automatic frame(input logic [15:0] ty, input logic [15:0] qt);
		logic [63:0] w;
		w = {ty, 16'h0000, 16'h0001, qt};
		@(posedge clk);
		sof <= 1'b1;
		@(posedge clk);
		sof <= 1'b0;
		for (int i = 0; i < 20; i++)
		begin
			vld <= 1'b1;
			data <= i < 12 ? 8'h00 : w[8 * (19 - i) +: 8];
			@(posedge clk);
		end
		vld <= 1'b0;
		eof <= 1'b1;
		good <= 1'b1;
		@(posedge clk);
		eof <= 1'b0;
		good <= 1'b0;
	endtask : frame
endmodule : link_partner

// [test/mac_flow_vlan_wakeup_cfg_checker.sv]
// Purpose: port checks for flow, vlan and wake slice
// Assumes: byte address is register index times four
// Notes: busy is visible only through flow reads
module mac_fvw_checker
(
	input wire logic        CLK_SYS,
	input wire logic        RESETN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        FULL_DUPLEX,
	input wire logic        TX_ENABLE,
	input wire logic        RX_EOF,
	input wire logic        RX_GOOD,
	input wire logic        RX_CONGESTED,
	input wire logic        PAUSE_TX_DONE,
	input wire logic        TX_HOLD,
	input wire logic        PAUSE_TX_REQ,
	input wire logic [15:0] PAUSE_TX_TIME,
	input wire logic        BACKPRESSURE,
	input wire logic        RX_VLAN,
	input wire logic [10:0] RX_MAX_LEN,
	input wire logic        RX_PAUSE_SEEN,
	input wire logic        WAKE_WR,
	input wire logic [2:0]  WAKE_IDX,
	input wire logic [31:0] WAKE_DATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr;
	logic       rd;
	logic [2:0] ptr_q;
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PENABLE && !PWRITE;
	// expected wake pointer, soft reset rewinds it
	always_ff @(posedge CLK_SYS or negedge RESETN)
		if (!RESETN)
			ptr_q <= 3'h0;
		else if (wr && PADDR == 12'h034 && PWDATA == 32'h00000001)
			ptr_q <= 3'h0;
		else if (WAKE_WR)
			ptr_q <= ptr_q + 3'h1;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	a_hold_after_pause: assert property ($rose(TX_HOLD) |-> $past(RX_PAUSE_SEEN))
		else $error("hold without pause");
	a_seen_cause: assert property (RX_PAUSE_SEEN |->
		$past(RX_EOF) && $past(RX_GOOD) && $past(FULL_DUPLEX)) else $error("bad pause decode");
	a_bp_cause: assert property (BACKPRESSURE |->
		$past(TX_ENABLE) && $past(RX_CONGESTED) && !$past(FULL_DUPLEX)) else $error("bad bp");
	a_busy_read: assert property (rd && PADDR == 12'h020 |=>
		PRDATA[0] == ($past(PAUSE_TX_REQ) | $past(BACKPRESSURE))) else $error("busy bit");
	a_req_done: assert property (PAUSE_TX_DONE && PAUSE_TX_REQ |=> !PAUSE_TX_REQ)
		else $error("req stuck");
	a_req_tx_on: assert property (PAUSE_TX_REQ |-> $past(TX_ENABLE) && $past(FULL_DUPLEX))
		else $error("req while tx off");
	a_time_field: assert property (wr && PADDR == 12'h020 |=>
		PAUSE_TX_TIME == $past(PWDATA[31:16])) else $error("pause time");
	a_len_vlan: assert property (RX_MAX_LEN == (RX_VLAN ? 11'h5f2 : 11'h5ee))
		else $error("max length");
	a_wake_data: assert property (wr && PADDR == 12'h02c |=>
		WAKE_WR && WAKE_DATA == $past(PWDATA)) else $error("wake data");
	a_wake_index: assert property (WAKE_WR |-> WAKE_IDX == ptr_q)
		else $error("wake index");
	a_wake_reads: assert property (rd && PADDR == 12'h02c |=> PRDATA == 32'h0)
		else $error("wake readable");
	cover property ($rose(TX_HOLD));
	cover property (WAKE_WR && WAKE_IDX == 3'h7);
	cover property ($rose(BACKPRESSURE));
endmodule : mac_fvw_checker
bind mac_flow_vlan_wakeup_cfg mac_fvw_checker chk_u
(
	.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.FULL_DUPLEX(FULL_DUPLEX), .TX_ENABLE(TX_ENABLE), .RX_EOF(RX_EOF),
	.RX_GOOD(RX_GOOD), .RX_CONGESTED(RX_CONGESTED), .PAUSE_TX_DONE(PAUSE_TX_DONE),
	.TX_HOLD(TX_HOLD), .PAUSE_TX_REQ(PAUSE_TX_REQ), .PAUSE_TX_TIME(PAUSE_TX_TIME),
	.BACKPRESSURE(BACKPRESSURE), .RX_VLAN(RX_VLAN), .RX_MAX_LEN(RX_MAX_LEN),
	.RX_PAUSE_SEEN(RX_PAUSE_SEEN), .WAKE_WR(WAKE_WR), .WAKE_IDX(WAKE_IDX),
	.WAKE_DATA(WAKE_DATA)
);

// [test/mac_flow_vlan_wakeup_cfg_tb.sv]
// Purpose: self-checking bench for flow, vlan and wake slice
// Assumes: zero wait apb slave, one rx byte per cycle
// Notes: pause length checked at both speeds, 10M run dominates time
module mac_flow_vlan_wakeup_cfg_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_SYS, RESETN, PSEL, PENABLE, PWRITE, FULL_DUPLEX, SPEED_100, TX_ENABLE;
	logic        RX_SOF, RX_VALID, RX_EOF, RX_GOOD, RX_CONGESTED, PAUSE_TX_DONE, PREADY;
	logic        PSLVERR, TX_HOLD, PAUSE_TX_REQ, BACKPRESSURE, RX_VLAN, RX_PAUSE_SEEN, WAKE_WR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, WAKE_DATA, wk_d, r;
	logic [15:0] PAUSE_TX_TIME;
	logic [10:0] RX_MAX_LEN;
	logic [7:0]  RX_DATA;
	logic [2:0]  WAKE_IDX, wk_i;
	int          num_errors = 0;
	int          n_compared = 0;
	mac_flow_vlan_wakeup_cfg dut_u
	(
		.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .FULL_DUPLEX(FULL_DUPLEX),
		.SPEED_100(SPEED_100), .TX_ENABLE(TX_ENABLE), .RX_SOF(RX_SOF),
		.RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_EOF(RX_EOF), .RX_GOOD(RX_GOOD),
		.RX_CONGESTED(RX_CONGESTED), .PAUSE_TX_DONE(PAUSE_TX_DONE), .TX_HOLD(TX_HOLD),
		.PAUSE_TX_REQ(PAUSE_TX_REQ), .PAUSE_TX_TIME(PAUSE_TX_TIME),
		.BACKPRESSURE(BACKPRESSURE), .RX_VLAN(RX_VLAN), .RX_MAX_LEN(RX_MAX_LEN),
		.RX_PAUSE_SEEN(RX_PAUSE_SEEN), .WAKE_WR(WAKE_WR), .WAKE_IDX(WAKE_IDX),
		.WAKE_DATA(WAKE_DATA)
	);
	link_partner lp_u (.clk(CLK_SYS), .lag(4'h9), .req(PAUSE_TX_REQ), .sof(RX_SOF),
		.vld(RX_VALID), .data(RX_DATA), .eof(RX_EOF), .good(RX_GOOD), .done(PAUSE_TX_DONE));
	initial
	begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS)
		if (WAKE_WR === 1'b1)
			{wk_i, wk_d} <= {WAKE_IDX, WAKE_DATA};
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do
			@(posedge CLK_SYS);
		while (PREADY !== 1'b1);
		r = PRDATA;
		{PSEL, PENABLE} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(e, r);
	endtask : rd
	task automatic s_wake;
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b1, 12'h02c, 32'hc0de0000 + i);
			repeat (2) @(negedge CLK_SYS);
			chk(i % 8, wk_i);
			chk(32'hc0de0000 + i, wk_d);
		end
		apb(1'b1, 12'h034, 32'h00000001);
		apb(1'b1, 12'h02c, 32'h0);
		repeat (2) @(negedge CLK_SYS);
		chk(32'h0, wk_i);
		rd(12'h02c, 32'h0);
	endtask : s_wake
	task automatic s_vlan;
		logic [15:0] t [3][3];
		t = '{'{16'h8100, 16'h0, 16'h8100}, '{16'h8100, 16'h0, 16'h0800},
			'{16'h0, 16'h8100, 16'h8100}};
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, 12'h024, {16'h0, t[k][0]});
			apb(1'b1, 12'h028, {16'h0, t[k][1]});
			lp_u.frame(t[k][2], 16'h0);
			@(negedge CLK_SYS);
			chk(k != 1, RX_VLAN);
			chk(k != 1 ? 32'h5f2 : 32'h5ee, RX_MAX_LEN);
		end
	endtask : s_vlan
	task automatic hold_len(output int n);
		lp_u.frame(16'h8808, 16'h0001);
		n = 0;
		for (int i = 0; i < 8 && TX_HOLD !== 1'b1; i++)
			@(negedge CLK_SYS);
		for (; TX_HOLD === 1'b1; n++)
			@(negedge CLK_SYS);
		@(posedge CLK_SYS);
	endtask : hold_len
	task automatic s_pause;
		int n;
		apb(1'b1, 12'h020, 32'h00000002);
		FULL_DUPLEX <= 1'b1;
		hold_len(n);
		chk(512 * 10 / 8, n);
		SPEED_100 <= 1'b0;
		hold_len(n);
		chk(512 * 100 / 8, n);
		FULL_DUPLEX <= 1'b0;
		hold_len(n);
		chk(32'h0, n);
		apb(1'b1, 12'h020, 32'h0);
		FULL_DUPLEX <= 1'b1;
		hold_len(n);
		chk(32'h0, n);
	endtask : s_pause
	task automatic s_tx;
		rd(12'h020, 32'h0);
		apb(1'b1, 12'h020, 32'h00050002);
		RX_CONGESTED <= 1'b1;
		rd(12'h020, 32'h00050003);
		chk(32'h5, PAUSE_TX_TIME);
		RX_CONGESTED <= 1'b0;
		for (int i = 0; i < 20 && PAUSE_TX_REQ === 1'b1; i++)
			@(negedge CLK_SYS);
		rd(12'h020, 32'h00050002);
		{TX_ENABLE, RX_CONGESTED} <= 2'b01;
		repeat (4) @(negedge CLK_SYS);
		chk(32'h0, {PAUSE_TX_REQ, BACKPRESSURE});
		@(posedge CLK_SYS);
		{FULL_DUPLEX, TX_ENABLE} <= 2'b01;
		repeat (3) @(negedge CLK_SYS);
		chk(32'h1, BACKPRESSURE);
		rd(12'h020, 32'h00050003);
		RX_CONGESTED <= 1'b0;
	endtask : s_tx
	task automatic complete_run;
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial
	begin
		{RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, FULL_DUPLEX} = '0;
		{SPEED_100, TX_ENABLE, RX_CONGESTED} = 3'b110;
		repeat (6) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		rd(12'h020, 32'h0);
		rd(12'h024, 32'h0);
		rd(12'h028, 32'h0);
		rd(12'h02c, 32'h0);
		rd(12'h03c, 32'h0);
		s_wake;
		s_vlan;
		s_pause;
		s_tx;
		complete_run;
	end
	initial
	begin
		#200000;
		num_errors++;
		complete_run;
	end
endmodule : mac_flow_vlan_wakeup_cfg_tb
